// file: rtl/ext_context_status_tracker.sv
// extension context status tracker: fp, vector and extension summary
// assumes execution units flag use and possible modification per cycle,
// and each extra extension reports its own status field
`include "ext_ctx_defs.svh"

module ext_context_status_tracker #(
  parameter bit HAS_FP = 1'b1,
  parameter bit HAS_VEC = 1'b1,
  parameter bit HAS_SMODE = 1'b1,
  parameter bit HAS_EXT = 1'b1,
  parameter bit FP_ZERO_IF_ABSENT = 1'b1,
  parameter bit VEC_ZERO_IF_ABSENT = 1'b1,
  parameter bit FP_TRACK = 1'b1,
  parameter bit VEC_TRACK = 1'b1
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // privileged software writes
  input wire logic i_fs_we,
  input wire ext_ctx_pkg::ctx_status_t i_fs_wdata,
  input wire logic i_vs_we,
  input wire ext_ctx_pkg::ctx_status_t i_vs_wdata,
  // execution units
  input wire logic i_fp_use,
  input wire logic i_fp_modify,
  input wire logic i_vec_use,
  input wire logic i_vec_modify,
  // extra extensions
  input wire ext_ctx_pkg::ctx_status_t i_ext_status [`CTX_EXT_UNITS],
  input wire logic [`CTX_EXT_UNITS-1:0] i_ext_use,
  // status fields
  output ext_ctx_pkg::ctx_status_t o_fp_state_status,
  output ext_ctx_pkg::ctx_status_t o_vector_state_status,
  output ext_ctx_pkg::ctx_status_t o_ext_state_summary,
  output logic o_dirty_summary_bit,
  // exceptions and initialization requests
  output logic o_fp_illegal,
  output logic o_vec_illegal,
  output logic [`CTX_EXT_UNITS-1:0] o_ext_illegal,
  output logic [`CTX_EXT_UNITS-1:0] o_ext_init
);
  import ext_ctx_pkg::*;

  // ==========================================================
  // configuration
  // absent hardware without supervisor mode forces zero; with it, optional
  localparam bit FP_LIVE = HAS_FP || (HAS_SMODE && !FP_ZERO_IF_ABSENT);
  localparam bit VEC_LIVE = HAS_VEC || (HAS_SMODE && !VEC_ZERO_IF_ABSENT);
  localparam bit [`CTX_UNITS-1:0] LIVE_V = {VEC_LIVE, FP_LIVE};
  localparam bit [`CTX_UNITS-1:0] TRACK_V = {VEC_TRACK, FP_TRACK};

  // ==========================================================
  // per-unit request vectors
  ext_ctx_if unit_if [`CTX_UNITS] ();
  ctx_status_t st [`CTX_UNITS];
  logic [`CTX_UNITS-1:0] we_v;
  ctx_status_t wdata_v [`CTX_UNITS];
  logic [`CTX_UNITS-1:0] use_v;
  logic [`CTX_UNITS-1:0] mod_v;
  ctx_status_t next_st [`CTX_UNITS];
  logic [`CTX_UNITS-1:0] illegal_v;

  // no enable, disable or unconfigure inputs exist for fp and vector:
  // only writes and execution move these fields
  always_comb begin
    we_v = {i_vs_we, i_fs_we};
    wdata_v[`CTX_UNIT_FP] = i_fs_wdata;
    wdata_v[`CTX_UNIT_VEC] = i_vs_wdata;
    use_v = {i_vec_use, i_fp_use};
    mod_v = {i_vec_modify, i_fp_modify};
  end

  for (genvar g = 0; g < `CTX_UNITS; g++) begin : g_unit
    assign unit_if[g].cur = st[g];
    assign unit_if[g].csr_we = we_v[g];
    assign unit_if[g].wdata = wdata_v[g];
    assign unit_if[g].use_req = use_v[g];
    assign unit_if[g].modify = mod_v[g];
    assign next_st[g] = unit_if[g].next;
    assign illegal_v[g] = unit_if[g].illegal;

    ext_ctx_unit #(
      .LIVE(LIVE_V[g]),
      .TRACK(TRACK_V[g])
    ) u_unit (
      .port_if(unit_if[g])
    );
  end

  // ==========================================================
  // extension summary
  ctx_status_t next_xs;
  ctx_status_t ext_prev [`CTX_EXT_UNITS];
  ctx_status_t next_ext_prev [`CTX_EXT_UNITS];
  logic [`CTX_EXT_UNITS-1:0] next_ext_init;

  // no software write path: summary only follows the extensions' own fields
  always_comb begin
    next_xs = ST_OFF;
    if (HAS_EXT) begin
      for (int i = 0; i < `CTX_EXT_UNITS; i++) begin
        if (i_ext_status[i] > next_xs) begin
          next_xs = i_ext_status[i];
        end
      end
    end
  end

  // a unit coming back on may carry another context's state
  always_comb begin
    for (int i = 0; i < `CTX_EXT_UNITS; i++) begin
      next_ext_prev[i] = HAS_EXT ? i_ext_status[i] : ST_OFF;
      next_ext_init[i] = HAS_EXT && ext_prev[i] == ST_OFF && i_ext_status[i] != ST_OFF;
    end
  end

  always_comb begin
    for (int i = 0; i < `CTX_EXT_UNITS; i++) begin
      o_ext_illegal[i] = HAS_EXT && i_ext_use[i] && i_ext_status[i] == ST_OFF;
    end
    o_fp_illegal = illegal_v[`CTX_UNIT_FP];
    o_vec_illegal = illegal_v[`CTX_UNIT_VEC];
  end

  // ==========================================================
  // dirty summary
  logic next_sd;

  always_comb begin
    next_sd = next_st[`CTX_UNIT_FP] == ST_DIRTY
      || next_st[`CTX_UNIT_VEC] == ST_DIRTY
      || next_xs == ST_DIRTY;
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < `CTX_UNITS; i++) begin
        st[i] <= ctx_status_t'(`CTX_ST_RESET);
      end
      for (int i = 0; i < `CTX_EXT_UNITS; i++) begin
        ext_prev[i] <= ctx_status_t'(`CTX_ST_RESET);
      end
      o_ext_state_summary <= ctx_status_t'(`CTX_ST_RESET);
      o_dirty_summary_bit <= 1'b0;
      o_ext_init <= '0;
    end else if (i_ce) begin
      st <= next_st;
      ext_prev <= next_ext_prev;
      o_ext_state_summary <= next_xs;
      o_dirty_summary_bit <= next_sd;
      o_ext_init <= next_ext_init;
    end
  end

  always_comb begin
    o_fp_state_status = st[`CTX_UNIT_FP];
    o_vector_state_status = st[`CTX_UNIT_VEC];
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic any_ext_dirty;
  logic any_ext_clean;
  logic all_ext_off;
  logic [`CTX_EXT_UNITS-1:0] ext_off_v;

  // level flags kept apart from the max loop, so a broken compare shows up
  always_comb begin
    any_ext_dirty = 1'b0;
    any_ext_clean = 1'b0;
    all_ext_off = 1'b1;
    ext_off_v = '0;
    for (int i = 0; i < `CTX_EXT_UNITS; i++) begin
      any_ext_dirty = any_ext_dirty || i_ext_status[i] == ST_DIRTY;
      any_ext_clean = any_ext_clean || i_ext_status[i] == ST_CLEAN;
      all_ext_off = all_ext_off && i_ext_status[i] == ST_OFF;
      ext_off_v[i] = i_ext_status[i] == ST_OFF;
    end
  end

  sequence s_fp_touch;
    i_ce && i_fp_modify && o_fp_state_status != ST_OFF;
  endsequence

  sequence s_fs_write_clean;
    i_ce && i_fs_we && !i_fp_modify && i_fs_wdata == ST_CLEAN;
  endsequence

  sequence s_ext0_turn_on;
    i_ce && HAS_EXT && ext_prev[0] == ST_OFF && i_ext_status[0] != ST_OFF;
  endsequence

  sequence s_ext1_turn_on;
    i_ce && HAS_EXT && ext_prev[1] == ST_OFF && i_ext_status[1] != ST_OFF;
  endsequence

  sequence s_fs_write_initial;
    i_ce && i_fs_we && !i_fp_modify && i_fs_wdata == ST_INITIAL;
  endsequence

  sequence s_fs_write_off;
    i_ce && i_fs_we && !i_fp_modify && i_fs_wdata == ST_OFF;
  endsequence

  sequence s_vs_write_clean;
    i_ce && i_vs_we && !i_vec_modify && i_vs_wdata == ST_CLEAN;
  endsequence

  AST_FP_MODIFY_DIRTY: assert property (s_fp_touch |=> o_fp_state_status == ST_DIRTY)
    else $error("fp status not dirty after modify");

  AST_VEC_MODIFY_DIRTY: assert property (
    i_ce && i_vec_modify && o_vector_state_status != ST_OFF |=> o_vector_state_status == ST_DIRTY)
    else $error("vector status not dirty after modify");

  AST_FP_OFF_ILLEGAL: assert property (
    i_fp_use |-> o_fp_illegal == (o_fp_state_status == ST_OFF))
    else $error("fp illegal flag does not match off status");

  AST_VEC_OFF_ILLEGAL: assert property (
    i_vec_use |-> o_vec_illegal == (o_vector_state_status == ST_OFF))
    else $error("vector illegal flag does not match off status");

  AST_FS_WRITE_LEGAL: assert property (
    s_fs_write_clean |=> o_fp_state_status == (!FP_LIVE ? ST_OFF : (FP_TRACK ? ST_CLEAN : ST_DIRTY)))
    else $error("fp status write not legalized");

  AST_FP_HARDWIRED: assert property (
    !FP_LIVE |-> o_fp_state_status == ST_OFF && (!o_dirty_summary_bit || o_ext_state_summary == ST_DIRTY
      || o_vector_state_status == ST_DIRTY))
    else $error("hardwired fp status not zero or raised dirty");

  AST_SD_MATCH: assert property (
    o_dirty_summary_bit == (o_fp_state_status == ST_DIRTY || o_vector_state_status == ST_DIRTY
      || o_ext_state_summary == ST_DIRTY))
    else $error("dirty summary bit mismatch");

  AST_XS_LEVELS: assert property (
    i_ce && HAS_EXT |=> o_ext_state_summary == ($past(any_ext_dirty) ? ST_DIRTY
      : ($past(all_ext_off) ? ST_OFF : ($past(any_ext_clean) ? ST_CLEAN : ST_INITIAL))))
    else $error("extension summary level wrong");

  AST_XS_ZERO_NO_EXT: assert property (!HAS_EXT |-> o_ext_state_summary == ST_OFF)
    else $error("extension summary not zero without extensions");

  AST_FREEZE: assert property (
    !i_ce |=> $stable(o_fp_state_status) && $stable(o_vector_state_status) && $stable(o_ext_state_summary))
    else $error("state moved while clock enable low");

  AST_EXT_INIT: assert property (s_ext0_turn_on |=> o_ext_init[0] ##1 (!$past(i_ce) || !o_ext_init[0]
    || ext_prev[0] == ST_OFF))
    else $error("extension init request missing");

  AST_EXT1_INIT: assert property (s_ext1_turn_on |=> o_ext_init[1])
    else $error("second extension init request missing");

  // ==========================================================
  // write legalization, hardwired-zero, illegal-flag, init and hold checks

  AST_FS_WRITE_INITIAL: assert property (
    s_fs_write_initial |=> o_fp_state_status == (!FP_LIVE ? ST_OFF : (FP_TRACK ? ST_INITIAL : ST_DIRTY)))
    else $error("fp initial write not legalized");

  AST_FS_WRITE_OFF: assert property (
    s_fs_write_off |=> o_fp_state_status == ST_OFF)
    else $error("fp off write not taken");

  AST_VS_WRITE_LEGAL: assert property (
    s_vs_write_clean |=> o_vector_state_status == (!VEC_LIVE ? ST_OFF : (VEC_TRACK ? ST_CLEAN : ST_DIRTY)))
    else $error("vector status write not legalized");

  AST_VEC_OFF_STAYS: assert property (
    i_ce && !i_vs_we && o_vector_state_status == ST_OFF |=> o_vector_state_status == ST_OFF)
    else $error("vector status left off without a write");

  AST_VEC_HARDWIRED: assert property (!VEC_LIVE |-> o_vector_state_status == ST_OFF)
    else $error("hardwired vector status not zero");

  AST_EXT_ILLEGAL: assert property (
    o_ext_illegal == (HAS_EXT ? (i_ext_use & ext_off_v) : {`CTX_EXT_UNITS{1'b0}}))
    else $error("extension illegal flags do not match off status");

  AST_EXT_NO_INIT: assert property (!HAS_EXT |-> o_ext_init == {`CTX_EXT_UNITS{1'b0}})
    else $error("init request without extensions");

  AST_SD_ZERO_HARDWIRED: assert property (
    !FP_LIVE && !VEC_LIVE && !HAS_EXT |-> !o_dirty_summary_bit)
    else $error("dirty summary set with all fields hardwired");

  AST_FP_HOLD: assert property (
    i_ce && !i_fs_we && !i_fp_modify |=> $stable(o_fp_state_status))
    else $error("fp status moved without write or modify");

  AST_VEC_HOLD: assert property (
    i_ce && !i_vs_we && !i_vec_modify |=> $stable(o_vector_state_status))
    else $error("vector status moved without write or modify");
endmodule

// file: rtl/ext_ctx_defs.svh
// constants of the extension context status tracker
// assumes inclusion by bare name from the package and the top module
`ifndef EXT_CTX_DEFS_SVH
`define EXT_CTX_DEFS_SVH

// ==========================================================
// status encoding
`define CTX_ST_OFF 2'h0
`define CTX_ST_INITIAL 2'h1
`define CTX_ST_CLEAN 2'h2
`define CTX_ST_DIRTY 2'h3
`define CTX_ST_RESET 2'h0

// ==========================================================
// sizes
`define CTX_ST_W 2
`define CTX_UNITS 2
`define CTX_UNIT_FP 0
`define CTX_UNIT_VEC 1
`define CTX_EXT_UNITS 2

`endif

// file: rtl/ext_ctx_pkg.sv
// types of the extension context status tracker
// assumes ext_ctx_defs.svh is on the include path
`include "ext_ctx_defs.svh"

package ext_ctx_pkg;

  // ==========================================================
  // status values
  typedef enum logic [`CTX_ST_W-1:0] {
    ST_OFF = `CTX_ST_OFF,
    ST_INITIAL = `CTX_ST_INITIAL,
    ST_CLEAN = `CTX_ST_CLEAN,
    ST_DIRTY = `CTX_ST_DIRTY
  } ctx_status_t;

endpackage

// file: rtl/ext_ctx_if.sv
// carrier between the tracker and its per-unit next-state logic
// assumes both ends sit in the core clock domain
interface ext_ctx_if;
  import ext_ctx_pkg::*;

  ctx_status_t cur;
  logic csr_we;
  ctx_status_t wdata;
  logic use_req;
  logic modify;
  ctx_status_t next;
  logic illegal;

  modport unit (
    input cur,
    input csr_we,
    input wdata,
    input use_req,
    input modify,
    output next,
    output illegal
  );

  modport core (
    output cur,
    output csr_we,
    output wdata,
    output use_req,
    output modify,
    input next,
    input illegal
  );
endinterface

// file: rtl/ext_ctx_unit.sv
// next-state logic for one status field (fp or vector)
// assumes the caller registers next and gates it with its clock enable
module ext_ctx_unit #(
  parameter bit LIVE = 1'b1,
  parameter bit TRACK = 1'b1
) (
  ext_ctx_if.unit port_if
);
  import ext_ctx_pkg::*;

  // ==========================================================
  // next status
  always_comb begin
    port_if.next = port_if.cur;
    if (!LIVE) begin
      port_if.next = ST_OFF;
    end else begin
      if (port_if.csr_we) begin
        // no datapath hook here: fp and vector registers keep their data
        port_if.next = port_if.wdata;
        if (!TRACK && port_if.wdata != ST_OFF) begin
          port_if.next = ST_DIRTY;
        end
      end
      // hardware set wins over a software write in the same cycle unless the field was off;
      // an unchanged-contents write still counts, tracking is imprecise
      if (port_if.modify && port_if.cur != ST_OFF) begin
        port_if.next = ST_DIRTY;
      end
    end
  end

  // ==========================================================
  // access check
  always_comb begin
    port_if.illegal = port_if.use_req && port_if.cur == ST_OFF;
  end
endmodule

// file: sim/ext_unit_model.sv
// partner model: the status fields of the extra stateful extensions
// assumes software sets a field by a one-cycle strobe in the core clock domain
`include "ext_ctx_defs.svh"

module ext_unit_model
  import ext_ctx_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // software write of one extension field
  input wire logic i_we,
  input wire logic i_idx,
  input wire ctx_status_t i_wdata,
  // status fields seen by the tracker
  output ctx_status_t o_status [`CTX_EXT_UNITS]
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // per-extension field, written only by software
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status[0] <= ST_OFF;
      o_status[1] <= ST_OFF;
    end else if (i_we) begin
      o_status[i_idx] <= i_wdata;
    end
  end
endmodule

// file: sim/ext_context_status_tracker_tb_top.sv
// testbench: full, hardwired-zero and untracked trackers side by side
// assumes the tracker answers one cycle after each sampling edge
`include "ext_ctx_defs.svh"

module ext_context_status_tracker_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ext_ctx_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic fs_we = 1'b0, vs_we = 1'b0, fp_use = 1'b0, fp_mod = 1'b0, vec_use = 1'b0, vec_mod = 1'b0;
  ctx_status_t fs_wd = ST_OFF, vs_wd = ST_OFF, m_wd = ST_OFF;
  logic m_we = 1'b0, m_idx = 1'b0;
  logic [1:0] ext_use = 2'h0;
  ctx_status_t ext_st [`CTX_EXT_UNITS];
  ctx_status_t fp [3], vec [3], sum [3];
  logic sd [3], fp_ill [3], vec_ill [3];
  logic [1:0] ext_ill [3], ext_init [3];
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  // ==========================================================
  // partner and trackers
  ext_unit_model partner (.i_clk(clk), .i_rst_n(rst_n), .i_we(m_we), .i_idx(m_idx), .i_wdata(m_wd),
    .o_status(ext_st));

  ext_context_status_tracker DUT (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_fs_we(fs_we),
    .i_fs_wdata(fs_wd), .i_vs_we(vs_we), .i_vs_wdata(vs_wd), .i_fp_use(fp_use), .i_fp_modify(fp_mod),
    .i_vec_use(vec_use), .i_vec_modify(vec_mod), .i_ext_status(ext_st), .i_ext_use(ext_use),
    .o_fp_state_status(fp[0]), .o_vector_state_status(vec[0]), .o_ext_state_summary(sum[0]),
    .o_dirty_summary_bit(sd[0]), .o_fp_illegal(fp_ill[0]), .o_vec_illegal(vec_ill[0]),
    .o_ext_illegal(ext_ill[0]), .o_ext_init(ext_init[0]));

  // no fp, no vector, optional zero taken, no extensions
  ext_context_status_tracker #(.HAS_FP(1'b0), .HAS_VEC(1'b0), .HAS_EXT(1'b0)) dut_zero (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_fs_we(fs_we),
    .i_fs_wdata(fs_wd), .i_vs_we(vs_we), .i_vs_wdata(vs_wd), .i_fp_use(fp_use), .i_fp_modify(fp_mod),
    .i_vec_use(vec_use), .i_vec_modify(vec_mod), .i_ext_status(ext_st), .i_ext_use(ext_use),
    .o_fp_state_status(fp[1]), .o_vector_state_status(vec[1]), .o_ext_state_summary(sum[1]),
    .o_dirty_summary_bit(sd[1]), .o_fp_illegal(fp_ill[1]), .o_vec_illegal(vec_ill[1]),
    .o_ext_illegal(ext_ill[1]), .o_ext_init(ext_init[1]));

  // dirtiness not tracked
  ext_context_status_tracker #(.FP_TRACK(1'b0), .VEC_TRACK(1'b0)) dut_untracked (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_fs_we(fs_we),
    .i_fs_wdata(fs_wd), .i_vs_we(vs_we), .i_vs_wdata(vs_wd), .i_fp_use(fp_use), .i_fp_modify(fp_mod),
    .i_vec_use(vec_use), .i_vec_modify(vec_mod), .i_ext_status(ext_st), .i_ext_use(ext_use),
    .o_fp_state_status(fp[2]), .o_vector_state_status(vec[2]), .o_ext_state_summary(sum[2]),
    .o_dirty_summary_bit(sd[2]), .o_fp_illegal(fp_ill[2]), .o_vec_illegal(vec_ill[2]),
    .o_ext_illegal(ext_ill[2]), .o_ext_init(ext_init[2]));

  // ==========================================================
  // helpers
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // called at a falling edge, returns two falling edges later;
  // the idle edge keeps back-to-back calls from retoggling the strobe
  task automatic swr(input ctx_status_t f, input ctx_status_t v);
    fs_we = 1'b1;
    fs_wd = f;
    vs_we = 1'b1;
    vs_wd = v;
    @(negedge clk);
    fs_we = 1'b0;
    vs_we = 1'b0;
    @(negedge clk);
  endtask

  // partner updates on one edge, tracker samples on the next
  task automatic mset(input logic idx, input ctx_status_t v);
    m_we = 1'b1;
    m_idx = idx;
    m_wd = v;
    @(negedge clk);
    m_we = 1'b0;
    @(negedge clk);
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_sw_write;
    for (int i = 0; i < 4; i++) begin
      swr(ctx_status_t'(i), ctx_status_t'(3 - i));
      chk(fp[0], 4'(i));
      chk(vec[0], 4'(3 - i));
      chk(sd[0], (i == 0 || i == 3) ? 4'h1 : 4'h0);
      chk(fp[2], (i == 1 || i == 2) ? 4'h3 : 4'(i));
      chk(vec[2], (i == 1 || i == 2) ? 4'h3 : 4'(3 - i));
      chk(fp[1], 4'h0);
      chk(vec[1], 4'h0);
      chk(sd[1], 4'h0);
    end
  endtask

  task automatic t_modify;
    swr(ST_CLEAN, ST_OFF);
    fp_use = 1'b1;
    fp_mod = 1'b1;
    vec_use = 1'b1;
    vec_mod = 1'b1;
    #1;
    chk(fp_ill[0], 4'h0);
    chk(vec_ill[0], 4'h1);
    chk(fp_ill[1], 4'h1);
    @(negedge clk);
    {fp_use, fp_mod, vec_use, vec_mod} = 4'h0;
    chk(fp[0], 4'(ST_DIRTY));
    chk(vec[0], 4'(ST_OFF));
    chk(sd[0], 4'h1);
    chk(fp[1], 4'h0);
  endtask

  // clock enable low: nothing may be taken
  task automatic t_hold;
    swr(ST_INITIAL, ST_INITIAL);
    ce = 1'b0;
    swr(ST_DIRTY, ST_CLEAN);
    ce = 1'b1;
    chk(fp[0], 4'(ST_INITIAL));
    chk(vec[0], 4'(ST_INITIAL));
  endtask

  // context switch: save dirty then mark clean, restore clean or initial
  task automatic t_ctx_switch;
    swr(ST_DIRTY, ST_DIRTY);
    chk(sd[0], 4'h1);
    swr(ST_CLEAN, ST_CLEAN);
    chk(fp[0], 4'(ST_CLEAN));
    chk(sd[0], 4'h0);
    swr(ST_INITIAL, ST_CLEAN);
    chk(fp[0], 4'(ST_INITIAL));
    chk(vec[0], 4'(ST_CLEAN));
    chk(fp[2], 4'(ST_DIRTY));
  endtask

  task automatic t_ext;
    mset(1'b0, ST_INITIAL);
    chk(sum[0], 4'h1);
    chk(ext_init[0], 4'h1);
    chk(sd[0], 4'h0);
    @(negedge clk);
    chk(ext_init[0], 4'h0);
    mset(1'b1, ST_CLEAN);
    chk(sum[0], 4'h2);
    mset(1'b0, ST_DIRTY);
    chk(sum[0], 4'h3);
    chk(sd[0], 4'h1);
    chk(sum[1], 4'h0);
    mset(1'b1, ST_OFF);
    ext_use = 2'h3;
    #1;
    chk(ext_ill[0], 4'h2);
    chk(ext_ill[1], 4'h0);
    @(negedge clk);
    ext_use = 2'h0;
    mset(1'b0, ST_OFF);
    chk(sum[0], 4'h0);
  endtask

  // ==========================================================
  // run and watchdog
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_sw_write();
    t_modify();
    t_hold();
    t_ctx_switch();
    t_ext();
    complete_run();
  end
endmodule
